/* core/rsq_pkg.sv */
/*
 Constants, field layout and types of the reset sequencer and supply monitor.
 Assumes a 100 ns CPU clock and one Wishbone register word.
*/
package rsq_pkg;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          CNT_W          = 16;
	localparam int          WB_AW          = 8;
	localparam int          WB_DW          = 32;

	// Byte address of the integrity control/status register
	localparam logic [7:0]  ICSR_ADDR      = 8'h00;
	localparam logic [7:0]  ICSR_RESET     = 8'h00;
	localparam int          BIT_AUX_IE     = 0;
	localparam int          BIT_AUX_FLAG   = 1;
	localparam int          BIT_LVD_RF     = 2;
	localparam int          BIT_PLL_LOCK   = 3;
	localparam int          BIT_WDG_RF     = 4;

	// Delay and fetch phase lengths in CPU cycles
	localparam int          DELAY_SHORT_CYC = 256;
	localparam int          DELAY_LONG_CYC  = 4096;
	localparam int          FETCH_CYC       = 2;

	// Reset vector, low byte first
	localparam logic [15:0] VEC_ADDR_LO    = 16'hfffe;
	localparam logic [15:0] VEC_ADDR_HI    = 16'hffff;

	typedef enum logic [1:0] {
		CLK_SRC_RC,
		CLK_SRC_EXT,
		CLK_SRC_XTAL
	} rsq_clk_src_t;

	typedef enum logic [1:0] {
		LVD_LEVEL_LOW,
		LVD_LEVEL_MED,
		LVD_LEVEL_HIGH
	} rsq_lvd_level_t;

	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_DELAY,
		ST_PLL,
		ST_FETCH,
		ST_RUN
	} rsq_state_t;
endpackage

/* core/rsq_top.sv */
/*
 Reset sequence unit with low-voltage and auxiliary-voltage supervision,
 reset cause flags and the integrity control/status register.
 Assumes analog comparators, PLL and watchdog outside; reset pin resolved
 by the surrounding pad from rst_pin_o and rst_pin_oe.
*/
// Local design decisions: the Wishbone register port and the address map.
// What this block does
// - All three reset sources pull the reset pin low; it stays low during delay.
// - After any reset the core fetches its vector from FFFEh-FFFFh.
// - Sequence runs active phase, then fixed delay, then vector fetch.
// - Delay is 256 cycles for RC or external clock, 4096 for crystal.
// - Vector fetch phase lasts exactly two clock cycles.
// - With PLL enabled, clock stays held for an extra start-up delay.
// - External pin low enters reset asynchronously, even with clock stopped.
// - Low-voltage reset drives the reset pin low for other devices.
// - Low-voltage detector only when configured; threshold low, medium or high.
// - Watchdog underflow drives the pin low at least the minimum pulse width.
// - Illegal opcode or prebyte detection also resets the device.
// - Auxiliary detector works only with low-voltage detector enabled.
// - Auxiliary flag follows comparator in real time and is read-only.
// - Aux interrupt requested on flag set if enabled and mask clear.
// - Aux interrupt wakes from wait, never from halt.
// - In halt the register contents freeze; aux flag freezes too and no new aux pending is latched.
// - Watchdog flag bit 4 set by watchdog, cleared by zero write, pin reset or LOW_VOLTAGE_DETECTOR.
// - Cause flags: pin 0/0, watchdog 0/1, low voltage 1/X.
// - PLL lock bit 3 is hardware-only, 1 when locked.
// - Low-voltage flag bit 2 set by LOW_VOLTAGE_DETECTOR reset, cleared by reading.
// - External or watchdog reset leaves the low-voltage flag set.
// - Bit 1 aux flag, bit 0 enable; pending clears on routine entry.
`timescale 1ns/1ps
module rsq_top #(
	parameter int WDG_PULSE_NS   = 20000,
	parameter int PLL_STARTUP_NS = 1000000
) (
	input  wire logic                           clk,
	input  wire logic                           nrst,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [rsq_pkg::WB_AW-1:0]      wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [rsq_pkg::WB_DW-1:0]      wb_dat_i,
	output      logic [rsq_pkg::WB_DW-1:0]      wb_dat_o,
	output      logic                           wb_ack_o,
	input  wire logic                           rst_pin_i,
	output      logic                           rst_pin_o,
	output      logic                           rst_pin_oe,
	input  wire logic                           lvd_option_en,
	input  wire rsq_pkg::rsq_lvd_level_t        lvd_option_level,
	input  wire rsq_pkg::rsq_clk_src_t          clk_src_option,
	input  wire logic                           pll_option_en,
	input  wire logic                           lvd_below_i,
	input  wire logic                           avd_below_i,
	input  wire logic                           pll_locked_i,
	input  wire logic                           wdg_underflow,
	input  wire logic                           illegal_opcode,
	input  wire logic                           halt_mode,
	input  wire logic                           wait_mode,
	input  wire logic                           global_irq_mask,
	input  wire logic                           aux_irq_ack,
	output      rsq_pkg::rsq_lvd_level_t        lvd_level_o,
	output      logic                           lvd_enable_o,
	output      logic                           core_rst_n,
	output      logic                           vector_fetch,
	output      logic [15:0]                    vector_addr,
	output      logic                           clk_hold,
	output      logic                           aux_irq_req,
	output      logic                           wait_wakeup
);
	import rsq_pkg::*;

	localparam int WDG_PULSE_CYC   =
		(WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PLL_STARTUP_CYC =
		(PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	rsq_state_t              state_r;
	rsq_state_t              state_nxt;
	logic [CNT_W-1:0]        cnt_r;
	logic [CNT_W-1:0]        cnt_nxt;
	logic [CNT_W-1:0]        pulse_r;
	logic                    pin_arst_n;
	logic [1:0]              pin_sync_r;
	logic [1:0]              lvd_sync_r;
	logic [1:0]              avd_sync_r;
	logic [1:0]              lock_sync_r;
	logic                    ext_low;
	logic                    lvd_act;
	logic                    int_hit;
	logic                    int_hold;
	logic                    src_any;
	logic                    oe_r;
	logic                    oe_d_r;
	logic                    core_rst_n_r;
	logic                    fetch_r;
	logic [15:0]             vec_r;
	logic                    hold_r;
	logic                    wdg_rf_r;
	logic                    lvd_rf_r;
	logic                    lock_r;
	logic                    aux_flag_r;
	logic                    aux_prev_r;
	logic                    aux_ie_r;
	logic                    aux_pend_r;
	logic                    aux_pend_nxt;
	logic                    irq_r;
	logic                    wake_r;
	logic                    ack_r;
	logic [WB_DW-1:0]        rdat_r;
	logic                    bus_req;
	logic                    hit;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [7:0]              reg_val;
	rsq_lvd_level_t          level_r;
	logic                    lvd_en_r;

	// The pin is only watched while we are not pulling it ourselves.
	// One extra cycle of masking after release lets the pull-up lift the
	// pin; otherwise our own release would read as an external pull.
	// Limitation: an outside pull in that one cycle is seen a cycle late.
	assign pin_arst_n = nrst & (rst_pin_i | oe_r | oe_d_r);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oe_d_r <= 1'b1;
		end else begin
			oe_d_r <= oe_r;
		end
	end

	// Reset-style synchroniser: entry is immediate, release takes two edges
	always_ff @(posedge clk or negedge pin_arst_n) begin
		if (!pin_arst_n) begin
			pin_sync_r <= 2'b00;
		end else begin
			pin_sync_r <= {pin_sync_r[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lvd_sync_r  <= 2'b00;
			avd_sync_r  <= 2'b00;
			lock_sync_r <= 2'b00;
		end else begin
			lvd_sync_r  <= {lvd_sync_r[0], lvd_below_i};
			avd_sync_r  <= {avd_sync_r[0], avd_below_i};
			lock_sync_r <= {lock_sync_r[0], pll_locked_i};
		end
	end

	// Option bits are static; registering them gives clean outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level_r  <= LVD_LEVEL_LOW;
			lvd_en_r <= 1'b0;
		end else begin
			level_r  <= lvd_option_level;
			lvd_en_r <= lvd_option_en;
		end
	end

	assign ext_low  = ~pin_sync_r[1];
	assign lvd_act  = lvd_en_r & lvd_sync_r[1];
	assign int_hit  = wdg_underflow | illegal_opcode;
	assign int_hold = lvd_act | int_hit | (pulse_r != '0);
	assign src_any  = ext_low | int_hold;

	// Minimum pin pulse after watchdog or illegal-opcode reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_r <= '0;
		end else if (int_hit) begin
			pulse_r <= CNT_W'(WDG_PULSE_CYC - 1);
		end else if (pulse_r != '0) begin
			pulse_r <= pulse_r - 1'b1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		unique case (state_r)
			ST_ACTIVE: begin
				if (!src_any) begin
					state_nxt = ST_DELAY;
					if (clk_src_option == CLK_SRC_XTAL) begin
						cnt_nxt = CNT_W'(DELAY_LONG_CYC - 1);
					end else begin
						cnt_nxt = CNT_W'(DELAY_SHORT_CYC - 1);
					end
				end
			end
			ST_DELAY: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (pll_option_en) begin
					state_nxt = ST_PLL;
					cnt_nxt   = CNT_W'(PLL_STARTUP_CYC - 1);
				end else begin
					state_nxt = ST_FETCH;
					cnt_nxt   = CNT_W'(FETCH_CYC - 1);
				end
			end
			ST_PLL: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					state_nxt = ST_FETCH;
					cnt_nxt   = CNT_W'(FETCH_CYC - 1);
				end
			end
			ST_FETCH: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
			end
		endcase
		// A new source restarts the sequence from any phase
		if (src_any) begin
			state_nxt = ST_ACTIVE;
			cnt_nxt   = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_ACTIVE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// External pulls are seen on the pin itself, so only drive for our own sources and in delay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oe_r <= 1'b1;
		end else begin
			oe_r <= (state_nxt == ST_DELAY) | int_hold;
		end
	end

	// Pin low also holds the core in reset with no clock edge needed
	always_ff @(posedge clk or negedge pin_arst_n) begin
		if (!pin_arst_n) begin
			core_rst_n_r <= 1'b0;
		end else begin
			core_rst_n_r <= (state_nxt == ST_RUN);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fetch_r <= 1'b0;
			vec_r   <= VEC_ADDR_LO;
			hold_r  <= 1'b0;
		end else begin
			fetch_r <= (state_nxt == ST_FETCH);
			hold_r  <= (state_nxt == ST_PLL);
			if (state_nxt == ST_FETCH && cnt_nxt == '0) begin
				vec_r <= VEC_ADDR_HI;
			end else begin
				vec_r <= VEC_ADDR_LO;
			end
		end
	end

	// Wishbone classic slave, one wait state, reads zero when unmapped
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign hit     = (wb_adr_i == ICSR_ADDR);
	assign reg_wr  = bus_req & hit & wb_we_i & wb_sel_i[0] & ~halt_mode;
	assign reg_rd  = bus_req & hit & ~wb_we_i & ~halt_mode;

	always_comb begin
		reg_val               = ICSR_RESET;
		reg_val[BIT_AUX_IE]   = aux_ie_r;
		reg_val[BIT_AUX_FLAG] = aux_flag_r;
		reg_val[BIT_LVD_RF]   = lvd_rf_r;
		reg_val[BIT_PLL_LOCK] = lock_r;
		reg_val[BIT_WDG_RF]   = wdg_rf_r;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r <= bus_req;
			if (bus_req && !wb_we_i && hit) begin
				rdat_r <= {{(WB_DW-8){1'b0}}, reg_val};
			end else begin
				rdat_r <= '0;
			end
		end
	end

	// Cause flags survive the reset sequence; besides nrst, a read clears this one and a pin or low-voltage reset or a zero write the watchdog flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lvd_rf_r <= 1'b0;
		end else if (lvd_act) begin
			lvd_rf_r <= 1'b1;
		end else if (reg_rd) begin
			lvd_rf_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdg_rf_r <= 1'b0;
		end else if (wdg_underflow) begin
			wdg_rf_r <= 1'b1;
		end else if (lvd_act || ext_low) begin
			wdg_rf_r <= 1'b0;
		end else if (reg_wr && !wb_dat_i[BIT_WDG_RF]) begin
			wdg_rf_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_r <= 1'b0;
		end else if (!halt_mode) begin
			lock_r <= lock_sync_r[1];
		end
	end

	// Upper bits are never stored, so a careless write cannot set them
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_ie_r <= 1'b0;
		end else if (!core_rst_n_r) begin
			aux_ie_r <= 1'b0;
		end else if (reg_wr) begin
			aux_ie_r <= wb_dat_i[BIT_AUX_IE];
		end
	end

	// Flag lags the comparator by the synchroniser plus this register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_flag_r <= 1'b0;
			aux_prev_r <= 1'b0;
		end else if (!halt_mode) begin
			aux_flag_r <= lvd_en_r & avd_sync_r[1];
			aux_prev_r <= aux_flag_r;
		end
	end

	// Pending latch: a new crossing beats a same-cycle acknowledge
	always_comb begin
		aux_pend_nxt = aux_pend_r;
		if (aux_irq_ack) begin
			aux_pend_nxt = 1'b0;
		end
		if (aux_flag_r && !aux_prev_r && !halt_mode) begin
			aux_pend_nxt = 1'b1;
		end
		if (!lvd_en_r || !core_rst_n_r) begin
			aux_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_pend_r <= 1'b0;
			irq_r      <= 1'b0;
			wake_r     <= 1'b0;
		end else begin
			aux_pend_r <= aux_pend_nxt;
			irq_r      <= aux_pend_nxt & aux_ie_r & ~global_irq_mask;
			wake_r     <= aux_pend_nxt & aux_ie_r & wait_mode
				& ~halt_mode;
		end
	end

	assign wb_dat_o     = rdat_r;
	assign wb_ack_o     = ack_r;
	assign rst_pin_o    = 1'b0;
	assign rst_pin_oe   = oe_r;
	assign lvd_level_o  = level_r;
	assign lvd_enable_o = lvd_en_r;
	assign core_rst_n   = core_rst_n_r;
	assign vector_fetch = fetch_r;
	assign vector_addr  = vec_r;
	assign clk_hold     = hold_r;
	assign aux_irq_req  = irq_r;
	assign wait_wakeup  = wake_r;
endmodule // rsq_top

/* verification/rsq_pin_model.sv */
/*
 Reset pin with its pull-up and the board circuitry that may pull it low.
 Assumes the design pulls the pin through rst_pin_oe only.
*/
`timescale 1ns/1ps
module rsq_pin_model (
	input  wire logic rst_pin_oe,
	input  wire logic ext_pull,
	output      logic pin
);
	// Wired low by either party; the pull-up wins only when both let go
	assign pin = !(rst_pin_oe || ext_pull);
endmodule // rsq_pin_model

/* verification/rsq_sva.sv */
/*
 Port checker of the reset sequencer and supply monitor.
 Assumes WDG_PULSE_NS of 500, i.e. five cycles of pin pulse.
*/
`timescale 1ns/1ps
module rsq_sva (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        rst_pin_oe,
	input wire logic        lvd_enable_o,
	input wire logic        lvd_below_i,
	input wire logic        pll_option_en,
	input wire logic        wdg_underflow,
	input wire logic        halt_mode,
	input wire logic        global_irq_mask,
	input wire logic        core_rst_n,
	input wire logic        vector_fetch,
	input wire logic [15:0] vector_addr,
	input wire logic        clk_hold,
	input wire logic        aux_irq_req,
	input wire logic        wait_wakeup
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	fetch_len_a: assert property ($rose(vector_fetch)
		|=> vector_fetch ##1 !vector_fetch) else $error("fetch length");
	fetch_addr_a: assert property ($rose(vector_fetch)
		|-> vector_addr == 16'hfffe ##1 vector_addr == 16'hffff)
		else $error("fetch address");
	core_free_a: assert property ($rose(core_rst_n)
		|-> $past(vector_fetch)) else $error("core freed early");
	delay_pin_a: assert property ($rose(vector_fetch) && !pll_option_en
		|-> $past(rst_pin_oe)) else $error("pin free in delay");
	wdg_pulse_a: assert property (wdg_underflow
		|=> rst_pin_oe [*5]) else $error("watchdog pulse short");
	lvd_pin_a: assert property ((lvd_enable_o && lvd_below_i) [*4]
		|-> rst_pin_oe) else $error("low voltage pin free");
	irq_mask_a: assert property (aux_irq_req
		|-> !$past(global_irq_mask)) else $error("request while masked");
	halt_wake_a: assert property (wait_wakeup
		|-> !$past(halt_mode)) else $error("wake in halt");
	pll_hold_a: assert property (clk_hold
		|-> pll_option_en) else $error("hold without pll");
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer");
endmodule // rsq_sva

bind rsq_top rsq_sva chk_u (.*);

/* verification/test_rsq_top.sv */
/*
 Self-checking bench of the reset sequencer with a flag model.
 Assumes PLL start-up of 10 cycles and a 5 cycle watchdog pulse.
*/
`timescale 1ns/1ps
module test_rsq_top;
	import rsq_pkg::*;
	logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rst_pin_i;
	logic rst_pin_o, rst_pin_oe, lvd_option_en, pll_option_en, ext_pull;
	logic lvd_below_i, avd_below_i, pll_locked_i, wdg_underflow;
	logic illegal_opcode, halt_mode, wait_mode, global_irq_mask;
	logic aux_irq_ack, lvd_enable_o, core_rst_n, vector_fetch, clk_hold;
	logic aux_irq_req, wait_wakeup, ie, wf, lf, af, lk;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, rs;
	logic [15:0] vector_addr;
	rsq_lvd_level_t lvd_option_level, lvd_level_o;
	rsq_clk_src_t   clk_src_option;
	int fails, checks, ocnt, hcnt;
	rsq_top #(.WDG_PULSE_NS(500), .PLL_STARTUP_NS(1000)) dut_u (.*);
	rsq_pin_model pin_u (.rst_pin_oe(rst_pin_oe), .ext_pull(ext_pull),
		.pin(rst_pin_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test();
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	// One classic cycle; the request stands until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n >= 20) begin
			fails++;
			end_of_test();
		end
	endtask
	// Reads clear the low-voltage flag except in halt
	task automatic rchk(input string n);
		bus(1'b0, ICSR_ADDR, 32'h0);
		chk(n, q, {27'h0, wf, lk, lf, af, ie});
		if (!halt_mode)
			lf = 1'b0;
	endtask
	// Counts pin and hold cycles until the vector fetch is seen
	task automatic seq();
		int n;
		{ocnt, hcnt, n} = '0;
		while (vector_fetch !== 1'b1 && n < 6000) begin
			@(posedge clk);
			ocnt += (rst_pin_oe === 1'b1);
			hcnt += (clk_hold === 1'b1);
			n++;
		end
		if (n >= 6000) begin
			fails++;
			end_of_test();
		end
		repeat (3) @(posedge clk);
	endtask
	// Source: 0 pin, 1 watchdog, 2 illegal opcode, else low voltage
	task automatic pulse(input int k, input int n);
		case (k)
			0: ext_pull <= 1'b1;
			1: wdg_underflow <= 1'b1;
			2: illegal_opcode <= 1'b1;
			default: lvd_below_i <= 1'b1;
		endcase
		repeat (n) @(posedge clk);
		{ext_pull, wdg_underflow, illegal_opcode, lvd_below_i} <= 4'h0;
		seq();
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, ext_pull, lvd_option_en} = '0;
		{pll_option_en, lvd_below_i, avd_below_i, pll_locked_i} = '0;
		{wdg_underflow, illegal_opcode, halt_mode, wait_mode} = '0;
		{global_irq_mask, aux_irq_ack, ie, wf, lf, af, lk} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		clk_src_option = CLK_SRC_RC;
		lvd_option_level = LVD_LEVEL_LOW;
		rs = 32'h0c1f;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		seq();
		rchk("reset value");
		for (int i = 0; i < 3; i++) begin
			clk_src_option <= rsq_clk_src_t'(i);
			lvd_option_level <= rsq_lvd_level_t'(i);
			pll_option_en <= (i == 1);
			pulse(0, 5);
			chk("delay", ocnt, (i == 2) ? 4096 : 256);
			chk("pll hold", hcnt, (i == 1) ? 10 : 0);
			chk("level", lvd_level_o, i);
		end
		bus(1'b1, ICSR_ADDR, 32'h1f);
		ie = 1'b1;
		rchk("write ones");
		bus(1'b1, ICSR_ADDR, 32'h0);
		ie = 1'b0;
		pulse(1, 1);
		wf = 1'b1;
		rchk("watchdog cause");
		for (int i = 0; i < 4; i++) begin
			rs = lfsr(rs);
			bus(1'b1, ICSR_ADDR, rs & 32'h1f);
			ie = rs[0];
			wf = wf & rs[4];
			rchk("random write");
		end
		bus(1'b1, ICSR_ADDR, 32'h0);
		{ie, wf} = 2'b00;
		pulse(2, 1);
		chk("illegal reset", ocnt > 0, 1);
		lvd_option_en <= 1'b1;
		pulse(3, 10);
		lf = 1'b1;
		halt_mode <= 1'b1;
		bus(1'b1, ICSR_ADDR, 32'h1);
		rchk("halt frozen");
		halt_mode <= 1'b0;
		rchk("lvd cause");
		rchk("lvd read clear");
		pulse(3, 10);
		pulse(1, 1);
		{lf, wf} = 2'b11;
		rchk("lvd kept by watchdog");
		pulse(1, 1);
		pulse(3, 10);
		pulse(0, 5);
		{lf, wf} = 2'b10;
		rchk("lvd kept by pin");
		pll_locked_i <= 1'b1;
		wait_mode <= 1'b1;
		bus(1'b1, ICSR_ADDR, 32'h1);
		{ie, lk} = 2'b11;
		avd_below_i <= 1'b1;
		repeat (5) @(posedge clk);
		af = 1'b1;
		chk("aux request", aux_irq_req, 1);
		chk("wait wake", wait_wakeup, 1);
		rchk("aux flag");
		aux_irq_ack <= 1'b1;
		@(posedge clk);
		aux_irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
		chk("aux ack", aux_irq_req, 0);
		avd_below_i <= 1'b0;
		global_irq_mask <= 1'b1;
		repeat (5) @(posedge clk);
		avd_below_i <= 1'b1;
		repeat (5) @(posedge clk);
		chk("masked", aux_irq_req, 0);
		lvd_option_en <= 1'b0;
		repeat (5) @(posedge clk);
		af = 1'b0;
		rchk("aux off");
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b0, 8'h04, 32'h0);
		chk("unmapped", q, 0);
		rchk("after unmapped");
		end_of_test();
	end
endmodule // test_rsq_top
